// >>> verilog/imu_regs.svh
// Behaviour
// - Run only when the condition code passes on current flags; else change nothing.
// - Multiply with a Booth array retiring eight multiplier bits per array cycle.
// - Short product writes first factor times second factor; addend is ignored.
// - Short accumulate writes first factor times second factor plus addend.
// - Short forms keep only the low 32 bits, same for signed and unsigned.
// - Flags change only when the flag-update bit is set.
// - Short flag update: negative from bit 31, zero when the 32-bit result is zero.
// - Short flag update leaves overflow alone; carry may hold any value.
// - Short product takes 1 + m cycles, short accumulate 1 + m + 1.
// - Short m is 1, 2, 3 when bits from 8, 16, 24 up are uniform; else 4.
// - Wide product gives a 64-bit result split into lower and upper destinations.
// - Wide accumulate adds the 64-bit addend_hi:addend_lo pair and writes the sum to the result registers.
// - Unsigned wide forms treat values as unsigned, signed ones as two's complement.
// - Wide flag update: negative from bit 63, zero when all 64 bits are zero.
// - Wide product takes 1 + m + 1 cycles, wide accumulate 1 + m + 2.
// - Signed wide m is 1, 2, 3 when bits 31 down to 8, 16, 24 uniform.
// - Unsigned wide m is 1, 2, 3 only when those upper bits are all zero.
`ifndef IMU_REGS_SVH
`define IMU_REGS_SVH

`define IMU_ADDR_W          8
`define IMU_OFF_FACTOR_A    8'h00
`define IMU_OFF_FACTOR_B    8'h04
`define IMU_OFF_ADDEND_LO   8'h08
`define IMU_OFF_ADDEND_HI   8'h0c
`define IMU_OFF_CTRL        8'h10
`define IMU_OFF_PSW         8'h14
`define IMU_OFF_RESULT_LO   8'h18
`define IMU_OFF_RESULT_HI   8'h1c
`define IMU_OFF_STATUS      8'h20

`define IMU_CTRL_OP_LSB     0
`define IMU_CTRL_OP_MSB     2
`define IMU_CTRL_SETF       3
`define IMU_CTRL_COND_LSB   4
`define IMU_CTRL_COND_MSB   7
`define IMU_CTRL_START      8

`define IMU_PSW_LSB         28
`define IMU_PSW_MSB         31
`define IMU_FLAG_N          3
`define IMU_FLAG_Z          2
`define IMU_FLAG_V          0

`define IMU_STAT_BUSY       0
`define IMU_STAT_EXEC       1
`define IMU_STAT_SKIP       2
`define IMU_STAT_M_LSB      4
`define IMU_STAT_M_MSB      6
`define IMU_STAT_CYC_LSB    8
`define IMU_STAT_CYC_MSB    11

`define IMU_ZERO32          32'h0000_0000
`define IMU_RST_COND        4'he
`define IMU_RST_FLAGS       4'h0
`define IMU_DIGIT_W         8
`define IMU_M_ONE           3'd1
`define IMU_M_TWO           3'd2
`define IMU_M_THREE         3'd3
`define IMU_M_MAX           3'd4
`define IMU_SEQ_CYCLES      4'd1
`define IMU_TAIL_SHORT      2'd0
`define IMU_TAIL_MLA        2'd1
`define IMU_TAIL_LONG       2'd1
`define IMU_TAIL_LONG_ACC   2'd2

`endif

// >>> verilog/imu_pkg.sv
package imu_pkg;

    typedef enum logic [2:0] {
        IMU_PRODUCT_LOW_OP              = 3'h0,
        IMU_PRODUCT_ACCUMULATE_LOW_OP   = 3'h1,
        IMU_UNSIGNED_WIDE_PRODUCT       = 3'h4,
        IMU_UNSIGNED_WIDE_PRODUCT_ACCUM = 3'h5,
        IMU_SIGNED_WIDE_PRODUCT         = 3'h6,
        IMU_SIGNED_WIDE_PRODUCT_ACCUM   = 3'h7
    } imu_op_t;

    typedef enum logic [3:0] {
        IMU_ST_IDLE  = 4'b0001,
        IMU_ST_SEQ   = 4'b0010,
        IMU_ST_ARRAY = 4'b0100,
        IMU_ST_TAIL  = 4'b1000
    } imu_state_t;

    // condition group, low bit of the code inverts the test
    typedef enum logic [2:0] {
        IMU_CC_ZERO   = 3'h0,
        IMU_CC_CARRY  = 3'h1,
        IMU_CC_NEG    = 3'h2,
        IMU_CC_OVF    = 3'h3,
        IMU_CC_HIGHER = 3'h4,
        IMU_CC_GE     = 3'h5,
        IMU_CC_GT     = 3'h6,
        IMU_CC_ALWAYS = 3'h7
    } imu_cond_t;

endpackage

// >>> verilog/imu_array_len.sv
`timescale 1ns/100ps
`include "imu_regs.svh"

module imu_array_len (
    input  wire logic [31:0] multiplier,
    input  wire logic        zeros_only,
    output logic      [2:0]  m_len
);
    logic [2:0] upper_uniform;

    genvar k;
    for (k = 1; k < 4; k++) begin : g_span
        wire all_zero = ~|multiplier[31:8*k];
        wire all_one  = &multiplier[31:8*k];
        assign upper_uniform[k-1] = all_zero | (all_one & ~zeros_only);
    end

    assign m_len = upper_uniform[0] ? `IMU_M_ONE :
                   upper_uniform[1] ? `IMU_M_TWO :
                   upper_uniform[2] ? `IMU_M_THREE : `IMU_M_MAX;

endmodule

// >>> verilog/imu_radix_step.sv
`timescale 1ns/100ps
`include "imu_regs.svh"

module imu_radix_step (
    input  wire logic [63:0]             acc_in,
    input  wire logic [63:0]             multiplicand,
    input  wire logic [`IMU_DIGIT_W-1:0] digit,
    input  wire logic                    digit_signed,
    input  wire logic [1:0]              position,
    output logic      [63:0]             acc_out
);
    // extension bit is the operand sign, not the digit's top bit: with early
    // termination the last digit's msb may differ from the uniform upper bits
    wire [63:0] digit_ext = {{(64-`IMU_DIGIT_W){digit_signed}}, digit};
    wire [63:0] partial   = multiplicand * digit_ext;
    wire [63:0] weighted  = partial << {position, 3'b000};

    assign acc_out = acc_in + weighted;

endmodule

// >>> verilog/imu_top.sv
`timescale 1ns/100ps
`include "imu_regs.svh"

module imu_top (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`IMU_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic                        stall,
    output logic                        done,
    output imu_pkg::imu_op_t            cur_op
);
    import imu_pkg::*;

    logic [31:0] factor_a;
    logic [31:0] factor_b;
    logic [31:0] addend_lo;
    logic [31:0] addend_hi;
    logic        ctrl_setf;
    logic [3:0]  ctrl_cond;
    logic [3:0]  psw;
    logic [31:0] res_lo;
    logic [31:0] res_hi;
    imu_state_t  state;
    logic [1:0]  step;
    logic [2:0]  m_len;
    logic [1:0]  tail_left;
    logic [63:0] acc;
    logic [3:0]  cnt;
    logic        last_exec;
    logic        last_skip;

    function automatic logic cond_eval(input logic [3:0] code, input logic [3:0] f);
        logic n;
        logic z;
        logic c;
        logic v;
        logic base;
        n = f[3];
        z = f[2];
        c = f[1];
        v = f[0];
        case (imu_cond_t'(code[3:1]))
            IMU_CC_ZERO:   base = z;
            IMU_CC_CARRY:  base = c;
            IMU_CC_NEG:    base = n;
            IMU_CC_OVF:    base = v;
            IMU_CC_HIGHER: base = c & ~z;
            IMU_CC_GE:     base = (n == v);
            IMU_CC_GT:     base = ~z & (n == v);
            IMU_CC_ALWAYS: base = 1'b1;
            default:       base = 1'b0;
        endcase
        // the all-ones code falls out as never
        cond_eval = base ^ code[0];
    endfunction

    // bus decode
    wire setup     = psel & ~penable;
    wire wr_en     = psel & penable & pready & pwrite;
    wire idle      = (state == IMU_ST_IDLE);
    wire sel_fa    = (paddr == `IMU_OFF_FACTOR_A);
    wire sel_fb    = (paddr == `IMU_OFF_FACTOR_B);
    wire sel_alo   = (paddr == `IMU_OFF_ADDEND_LO);
    wire sel_ahi   = (paddr == `IMU_OFF_ADDEND_HI);
    wire sel_ctrl  = (paddr == `IMU_OFF_CTRL);
    wire sel_psw   = (paddr == `IMU_OFF_PSW);
    wire sel_rlo   = (paddr == `IMU_OFF_RESULT_LO);
    wire sel_rhi   = (paddr == `IMU_OFF_RESULT_HI);
    wire sel_stat  = (paddr == `IMU_OFF_STATUS);
    wire mapped    = sel_fa | sel_fb | sel_alo | sel_ahi | sel_ctrl | sel_psw | sel_rlo | sel_rhi | sel_stat;
    // operands and flags are frozen while busy so the array sees stable inputs
    wire wr_idle   = wr_en & idle;
    wire start     = wr_idle & sel_ctrl & pwdata[`IMU_CTRL_START];

    // operation decode
    wire op_acc      = (cur_op == IMU_PRODUCT_ACCUMULATE_LOW_OP) | (cur_op == IMU_UNSIGNED_WIDE_PRODUCT_ACCUM) |
                       (cur_op == IMU_SIGNED_WIDE_PRODUCT_ACCUM);
    wire op_unsigned = (cur_op == IMU_UNSIGNED_WIDE_PRODUCT) | (cur_op == IMU_UNSIGNED_WIDE_PRODUCT_ACCUM);
    wire op_long     = op_unsigned | (cur_op == IMU_SIGNED_WIDE_PRODUCT) | (cur_op == IMU_SIGNED_WIDE_PRODUCT_ACCUM);
    wire [1:0] tail_need = op_long ? (op_acc ? `IMU_TAIL_LONG_ACC : `IMU_TAIL_LONG) :
                                     (op_acc ? `IMU_TAIL_MLA : `IMU_TAIL_SHORT);
    wire cond_pass   = cond_eval(ctrl_cond, psw);

    // array datapath
    wire [2:0]  m_calc;
    wire [31:0] fb_shift  = factor_b >> {step, 3'b000};
    wire        last_step = ({1'b0, step} == (m_len - `IMU_M_ONE));
    // short forms use the signed view: the low word is the same either way
    wire        dsigned   = ~op_unsigned & last_step & factor_b[31];
    wire [63:0] a_ext     = op_unsigned ? {`IMU_ZERO32, factor_a} : {{32{factor_a[31]}}, factor_a};
    wire [63:0] next_acc;
    wire [63:0] addend64  = op_long ? {addend_hi, addend_lo} : {`IMU_ZERO32, addend_lo};
    wire        first_tail = (tail_left == tail_need);
    wire [63:0] tail_acc  = (first_tail & op_acc) ? acc + addend64 : acc;
    wire        array_end = (state == IMU_ST_ARRAY) & last_step;
    wire        writeback = (array_end & (tail_need == `IMU_TAIL_SHORT)) |
                            ((state == IMU_ST_TAIL) & (tail_left == 2'd1));
    wire        skip      = (state == IMU_ST_SEQ) & ~cond_pass;
    wire        finish    = writeback | skip;
    wire [63:0] final_val = (state == IMU_ST_ARRAY) ? next_acc : tail_acc;
    wire        flag_n    = op_long ? final_val[63] : final_val[31];
    wire        flag_z    = op_long ? (final_val == 64'h0) : (final_val[31:0] == `IMU_ZERO32);

    imu_array_len u_len (
        .multiplier (factor_b),
        .zeros_only (op_unsigned),
        .m_len      (m_calc)
    );

    imu_radix_step u_step (
        .acc_in       (acc),
        .multiplicand (a_ext),
        .digit        (fb_shift[`IMU_DIGIT_W-1:0]),
        .digit_signed (dsigned),
        .position     (step),
        .acc_out      (next_acc)
    );

    // read side
    logic [31:0] ctrl_rd;
    logic [31:0] psw_rd;
    logic [31:0] stat_rd;
    always_comb begin
        ctrl_rd = `IMU_ZERO32;
        ctrl_rd[`IMU_CTRL_OP_MSB:`IMU_CTRL_OP_LSB] = cur_op;
        ctrl_rd[`IMU_CTRL_SETF] = ctrl_setf;
        ctrl_rd[`IMU_CTRL_COND_MSB:`IMU_CTRL_COND_LSB] = ctrl_cond;
        psw_rd = `IMU_ZERO32;
        psw_rd[`IMU_PSW_MSB:`IMU_PSW_LSB] = psw;
        stat_rd = `IMU_ZERO32;
        stat_rd[`IMU_STAT_BUSY] = ~idle;
        stat_rd[`IMU_STAT_EXEC] = last_exec;
        stat_rd[`IMU_STAT_SKIP] = last_skip;
        stat_rd[`IMU_STAT_M_MSB:`IMU_STAT_M_LSB] = m_len;
        stat_rd[`IMU_STAT_CYC_MSB:`IMU_STAT_CYC_LSB] = cnt;
    end

    wire [31:0] rdata = sel_fa   ? factor_a  :
                        sel_fb   ? factor_b  :
                        sel_alo  ? addend_lo :
                        sel_ahi  ? addend_hi :
                        sel_ctrl ? ctrl_rd   :
                        sel_psw  ? psw_rd    :
                        sel_rlo  ? res_lo    :
                        sel_rhi  ? res_hi    :
                        sel_stat ? stat_rd   : `IMU_ZERO32;

    // answer is prepared in the setup cycle so every output stays a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= `IMU_ZERO32;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata  <= pwrite ? `IMU_ZERO32 : rdata;
                pslverr <= ~mapped;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            factor_a  <= `IMU_ZERO32;
            factor_b  <= `IMU_ZERO32;
            addend_lo <= `IMU_ZERO32;
            addend_hi <= `IMU_ZERO32;
            cur_op    <= IMU_PRODUCT_LOW_OP;
            ctrl_setf <= 1'b0;
            ctrl_cond <= `IMU_RST_COND;
        end else if (wr_idle) begin
            if (sel_fa) factor_a <= pwdata;
            if (sel_fb) factor_b <= pwdata;
            if (sel_alo) addend_lo <= pwdata;
            if (sel_ahi) addend_hi <= pwdata;
            if (sel_ctrl) begin
                cur_op    <= imu_op_t'(pwdata[`IMU_CTRL_OP_MSB:`IMU_CTRL_OP_LSB]);
                ctrl_setf <= pwdata[`IMU_CTRL_SETF];
                ctrl_cond <= pwdata[`IMU_CTRL_COND_MSB:`IMU_CTRL_COND_LSB];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= IMU_ST_IDLE;
        end else begin
            case (state)
                IMU_ST_IDLE:  if (start) state <= IMU_ST_SEQ;
                IMU_ST_SEQ:   state <= cond_pass ? IMU_ST_ARRAY : IMU_ST_IDLE;
                IMU_ST_ARRAY: if (last_step) state <= writeback ? IMU_ST_IDLE : IMU_ST_TAIL;
                IMU_ST_TAIL:  if (writeback) state <= IMU_ST_IDLE;
                default:      state <= IMU_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step      <= 2'd0;
            m_len     <= `IMU_M_ONE;
            tail_left <= 2'd0;
            acc       <= 64'h0;
        end else if (state == IMU_ST_SEQ) begin
            step  <= 2'd0;
            m_len <= m_calc;
            acc   <= 64'h0;
        end else if (state == IMU_ST_ARRAY) begin
            step      <= step + 2'd1;
            acc       <= next_acc;
            tail_left <= tail_need;
        end else if (state == IMU_ST_TAIL) begin
            tail_left <= tail_left - 2'd1;
            acc       <= tail_acc;
        end
    end

    // write-back of destination and flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_lo <= `IMU_ZERO32;
            res_hi <= `IMU_ZERO32;
            psw    <= `IMU_RST_FLAGS;
        end else if (writeback) begin
            res_lo <= final_val[31:0];
            if (op_long) res_hi <= final_val[63:32];
            if (ctrl_setf) begin
                psw[`IMU_FLAG_N] <= flag_n;
                psw[`IMU_FLAG_Z] <= flag_z;
            end
        end else if (wr_idle & sel_psw) begin
            psw <= pwdata[`IMU_PSW_MSB:`IMU_PSW_LSB];
        end
    end

    // carry and overflow are never touched by the multiplier, a legal meaningless value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stall     <= 1'b0;
            done      <= 1'b0;
            cnt       <= 4'd0;
            last_exec <= 1'b0;
            last_skip <= 1'b0;
        end else begin
            done <= finish;
            if (start) stall <= 1'b1;
            else if (finish) stall <= 1'b0;
            if (start) cnt <= 4'd0;
            else if (!idle) cnt <= cnt + 4'd1;
            if (finish) begin
                last_exec <= writeback;
                last_skip <= skip;
            end
        end
    end

    // checks
    wire [31:0] ref_short = factor_a * factor_b;
    wire [63:0] ref_u     = {`IMU_ZERO32, factor_a} * {`IMU_ZERO32, factor_b};
    wire [63:0] ref_s     = {{32{factor_a[31]}}, factor_a} * {{32{factor_b[31]}}, factor_b};
    wire        fin_exec  = done & last_exec;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_skip_seen;
        (state == IMU_ST_SEQ) && !cond_pass;
    endsequence
    sequence s_busy_pair;
        stall ##1 stall;
    endsequence

    a_skip_keeps: assert property (s_skip_seen |=> done && !last_exec && $stable(res_lo) && $stable(psw))
        else $error("skipped multiply changed state");
    a_array_bound: assert property (state == IMU_ST_ARRAY |-> ({1'b0, step} < m_len) && (m_len <= `IMU_M_MAX))
        else $error("array ran past its length");
    a_short_prod: assert property (fin_exec && cur_op == IMU_PRODUCT_LOW_OP |-> res_lo == ref_short)
        else $error("short product wrong");
    a_short_accum: assert property (fin_exec && cur_op == IMU_PRODUCT_ACCUMULATE_LOW_OP |->
                                    res_lo == ref_short + addend_lo)
        else $error("short accumulate wrong");
    a_wide_unsigned: assert property (fin_exec && cur_op == IMU_UNSIGNED_WIDE_PRODUCT |-> {res_hi, res_lo} == ref_u)
        else $error("unsigned wide product wrong");
    a_wide_signed: assert property (fin_exec && cur_op == IMU_SIGNED_WIDE_PRODUCT |-> {res_hi, res_lo} == ref_s)
        else $error("signed wide product wrong");
    a_wide_accum: assert property (fin_exec && cur_op == IMU_SIGNED_WIDE_PRODUCT_ACCUM |->
                                   {res_hi, res_lo} == ref_s + {addend_hi, addend_lo})
        else $error("wide accumulate wrong");
    a_flags_kept: assert property (done && !(last_exec && ctrl_setf) |-> $stable(psw))
        else $error("flags changed without update bit");
    a_short_flags: assert property (fin_exec && ctrl_setf && !op_long |-> psw[`IMU_FLAG_N] == res_lo[31] &&
                                    psw[`IMU_FLAG_Z] == (res_lo == `IMU_ZERO32) && $stable(psw[`IMU_FLAG_V]))
        else $error("short flags wrong");
    a_wide_flags: assert property (fin_exec && ctrl_setf && op_long |-> psw[`IMU_FLAG_N] == res_hi[31] &&
                                   psw[`IMU_FLAG_Z] == ({res_hi, res_lo} == 64'h0))
        else $error("wide flags wrong");
    a_cycle_total: assert property (fin_exec |-> cnt == `IMU_SEQ_CYCLES + {1'b0, m_len} + {2'b00, tail_need})
        else $error("operation took the wrong number of cycles");
    a_len_short: assert property ((state == IMU_ST_SEQ) && !op_long && factor_b[31:8] == {24{factor_b[31]}} |=>
                                  m_len == `IMU_M_ONE)
        else $error("short array length wrong");
    a_len_signed: assert property ((state == IMU_ST_SEQ) && op_long && !op_unsigned &&
                                   factor_b[31:24] == {8{factor_b[31]}} && factor_b[31:16] != {16{factor_b[31]}} |=>
                                   m_len == `IMU_M_THREE)
        else $error("signed wide array length wrong");
    a_len_unsigned: assert property ((state == IMU_ST_SEQ) && op_unsigned && factor_b[31:8] == 24'h0 |=>
                                     m_len == `IMU_M_ONE)
        else $error("unsigned wide array length wrong");
    a_stall_span: assert property (start ##1 cond_pass |-> s_busy_pair ##[0:6] (!stall && done))
        else $error("stall did not span the operation");
    a_skip_release: assert property (s_skip_seen |=> !stall && done)
        else $error("skipped multiply kept the pipeline stalled");

endmodule

// >>> dv/imu_host_model.sv
`timescale 1ns/100ps
`include "imu_regs.svh"

module imu_host_model (
    input  wire logic                   pclk,
    output logic                        psel,
    output logic                        penable,
    output logic                        pwrite,
    output logic [`IMU_ADDR_W-1:0]      paddr,
    output logic [31:0]                 pwdata,
    input  wire logic [31:0]            prdata,
    input  wire logic                   pready,
    input  wire logic                   pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // called just after a rising edge; one idle cycle after each transfer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends a wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

// >>> dv/integer_multiply_unit_tb.sv
`timescale 1ns/100ps
`include "imu_regs.svh"

module integer_multiply_unit_tb;
    import imu_pkg::*;
    localparam logic [31:0] LO = 32'h0000_00c8;
    localparam logic [31:0] HI = 32'h8000_0001;
    logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, done, er;
    logic [`IMU_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata, prdata, rd, exp_lo, exp_hi;
    logic [3:0]             exp_f;
    imu_op_t                cur_op;
    int                     errors, num_checks, cyc, n_done, n_ops;
    logic [31:0]            bv [5] = '{32'h14, 32'hffff_ff80, 32'h1234, 32'hab_cdef, 32'h1234_5678};
    imu_op_t                ol [6] = '{IMU_PRODUCT_LOW_OP, IMU_PRODUCT_ACCUMULATE_LOW_OP, IMU_UNSIGNED_WIDE_PRODUCT,
                                       IMU_UNSIGNED_WIDE_PRODUCT_ACCUM, IMU_SIGNED_WIDE_PRODUCT,
                                       IMU_SIGNED_WIDE_PRODUCT_ACCUM};

    imu_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                 .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                 .stall(stall), .done(done), .cur_op(cur_op));
    imu_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                         .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task final_report;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (done === 1'b1)
            n_done++;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, er);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rd, er);
        check(rd, exp);
    endtask

    function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
        logic r;
        case (c[3:1])
            3'h0: r = f[2];
            3'h1: r = f[1];
            3'h2: r = f[3];
            3'h3: r = f[0];
            3'h4: r = f[1] & ~f[2];
            3'h5: r = f[3] == f[0];
            3'h6: r = ~f[2] & (f[3] == f[0]);
            default: r = 1'b1;
        endcase
        return r ^ c[0];
    endfunction

    // unsigned wide forms only accept all-zero upper bits
    function automatic logic [2:0] m_of(input logic [31:0] b, input logic u);
        for (int k = 1; k < 4; k++)
            if ((b >> (8 * k)) == 32'h0 || (!u && ($signed(b) >>> (8 * k)) == -1))
                return 3'(k);
        return 3'd4;
    endfunction

    task run_op(input imu_op_t op, input logic sf, input logic [3:0] c, input logic [31:0] a, input logic [31:0] b);
        logic [63:0] p;
        logic [2:0]  m;
        logic [3:0]  n;
        logic [31:0] st;
        logic        x, s;
        s = op[2] & op[1];
        m = m_of(b, op[2] & ~op[1]);
        n = 4'(1 + m + (op == IMU_PRODUCT_LOW_OP ? 0 : (op[2] & op[0]) ? 2 : 1));
        x = cond_ok(c, exp_f);
        wr(`IMU_OFF_FACTOR_A, a);
        wr(`IMU_OFF_FACTOR_B, b);
        wr(`IMU_OFF_ADDEND_LO, LO);
        wr(`IMU_OFF_ADDEND_HI, HI);
        wr(`IMU_OFF_CTRL, {23'h0, 1'b1, c, sf, op});
        check(32'(cur_op), 32'(op));
        if (x && n >= 4)
            wr(`IMU_OFF_PSW, 32'hf000_0000);
        st = 32'h1;
        for (int i = 0; i < 40 && st[0] !== 1'b0; i++)
            host.xfer(1'b0, `IMU_OFF_STATUS, 32'h0, st, er);
        if (x) begin
            p = {{32{s & a[31]}}, a} * {{32{s & b[31]}}, b};
            if (op == IMU_PRODUCT_ACCUMULATE_LOW_OP)
                p = p + {32'h0, LO};
            if (op[2] & op[0])
                p = p + {HI, LO};
            exp_lo = p[31:0];
            if (op[2])
                exp_hi = p[63:32];
            if (sf)
                exp_f = {op[2] ? p[63] : p[31], op[2] ? p == 64'h0 : p[31:0] == 32'h0, exp_f[1:0]};
            check(32'(st[6:4]), 32'(m));
        end
        check(32'({st[11:8], st[2:0]}), x ? 32'({n, 3'b010}) : 32'h0000_000c);
        rdc(`IMU_OFF_RESULT_LO, exp_lo);
        rdc(`IMU_OFF_RESULT_HI, exp_hi);
        rdc(`IMU_OFF_PSW, {exp_f, 28'h0});
        n_ops++;
    endtask

    initial begin
        presetn = 1'b0;
        exp_lo = 32'h0;
        exp_hi = 32'h0;
        exp_f = 4'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(`IMU_OFF_PSW, 32'h0);
        rdc(`IMU_OFF_CTRL, 32'h0000_00e0);
        check(32'(er), 32'h0);
        rdc(8'h24, 32'h0);
        check(32'(er), 32'h1);
        wr(`IMU_OFF_PSW, 32'h3000_0000);
        exp_f = 4'h3;
        foreach (ol[i])
            foreach (bv[j]) begin
                run_op(ol[i], 1'b1, 4'he, 32'hffff_fff6, bv[j]);
                run_op(ol[i], 1'b1, 4'he, 32'h0, bv[j]);
            end
        wr(`IMU_OFF_PSW, 32'h6000_0000);
        exp_f = 4'h6;
        for (int c = 0; c < 16; c++)
            run_op(IMU_PRODUCT_LOW_OP, 1'b0, 4'(c), 32'h7 + c, 32'h9);
        run_op(IMU_SIGNED_WIDE_PRODUCT, 1'b1, 4'hf, 32'h5, 32'h3);
        repeat (5) @(posedge pclk);
        check(n_done, n_ops);
        final_report();
    end
endmodule
